/* File: design/chg_edge_flag.sv */
// One sticky read-clear event flag with rising or dual edge capture.
`timescale 1ns/100ps
module chg_edge_flag
  import chg_pkg::*;
#(
  parameter bit DUAL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cond,
  input wire logic clr,
  output logic flag
);

  chg_flag_s s_q; // Registered state.
  chg_flag_s s_d; // Next state.
  logic hit; // Qualifying edge seen this cycle.

  // Edge detect; a new edge wins over a clear in the same cycle.
  always_comb begin
    s_d = s_q;
    if (DUAL) begin
      hit = cond ^ s_q.prev;
    end else begin
      hit = cond & ~s_q.prev;
    end
    s_d.prev = cond;
    s_d.flag = hit | (s_q.flag & ~clr);
  end

  // Synchronous reset clears both the flag and the edge history.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

endmodule

/* File: design/chg_params.svh */
// Register offsets, field positions, reset values and timer counts.
`ifndef CHG_PARAMS_SVH
`define CHG_PARAMS_SVH

// Register offsets on the byte register port.
`define CHG_ADDR_CHARGE_CONTROL_ONE 8'h01
`define CHG_ADDR_CHARGE_CONTROL_TWO 8'h02
`define CHG_ADDR_STAT 8'h03
`define CHG_ADDR_CH1 8'h04
`define CHG_ADDR_CH2 8'h05
`define CHG_ADDR_BST 8'h06

// Control register reset values.
`define CHG_CHARGE_CONTROL_ONE_RST 8'h51
`define CHG_CHARGE_CONTROL_TWO_RST 8'h1E

// Control register one bit positions.
`define CHG_C1_REG_RST 7
`define CHG_C1_CHARGE_ENABLE_BIT 6
`define CHG_C1_BOOST_EN 5
`define CHG_C1_BATT_TEMP 4
`define CHG_C1_TJ_OPT 3
`define CHG_C1_FORCE_EOC 2
`define CHG_C1_TMR_RST 1
`define CHG_C1_IRQ_MASK 0

// Control register two bit positions.
`define CHG_C2_WDOG_DIS 7
`define CHG_C2_CTMR_DIS 6
`define CHG_C2_POWER_PATH_ENABLE 5
`define CHG_C2_XCVR_EN 4
`define CHG_C2_FLAG_MASK 3
`define CHG_C2_ILIM_SRC 2
`define CHG_C2_ILIM_EN 1
`define CHG_C2_AUTO_CURRENT_ENABLE 0

// Control two bits restored on boost mode entry.
`define CHG_C2_BOOST_RST_MASK 8'hE7

// Flag vector layout: which flags live in which register.
`define CHG_NFLAGS 15
`define CHG_FL_STAT 15'h001F
`define CHG_FL_CH1 15'h01E0
`define CHG_FL_CH2 15'h3E00
`define CHG_FL_BST 15'h4000
// Flags latched on both edges; the rest only on the rising edge.
`define CHG_FL_DUAL 15'h47FF
// Flags cleared on boost mode, charge mode and timer reset events.
`define CHG_FL_BOOST_CLR 15'h3FF0
`define CHG_FL_CHG_CLR 15'h4000
`define CHG_FL_TMR_CLR 15'h3800

// Timer periods in seconds and their cycle counts at the clock rate.
`define CHG_CLK_HZ 40'd100000000
`define CHG_WDOG_S 40'd32
`define CHG_BUS_S 40'd2048
`define CHG_CTMR_S 40'd3600
`define CHG_WDOG_CYCLES (`CHG_WDOG_S * `CHG_CLK_HZ)
`define CHG_BUS_CYCLES (`CHG_BUS_S * `CHG_CLK_HZ)
`define CHG_CTMR_CYCLES (`CHG_CTMR_S * `CHG_CLK_HZ)

`endif

/* File: design/chg_pkg.sv */
// Types shared by the charger control and event flag logic.
package chg_pkg;

  // Cycle counter wide enough for the longest safety timer.
  typedef logic [39:0] chg_count_t;

  // State of one read-clear event flag.
  typedef struct packed {
    logic prev;
    logic flag;
  } chg_flag_s;

  // State of one timeout timer.
  typedef struct packed {
    chg_count_t cnt;
    logic expired;
  } chg_timer_s;

  // State of the register bank top.
  typedef struct packed {
    logic [7:0] charge_control_one;
    logic [7:0] charge_control_two;
    logic [7:0] rdata;
    logic boost_pin_prev;
    logic irq_n;
    logic flag_req;
    logic eoc_force;
    logic current_reduce;
    logic boost_run;
    logic batt_temp_fault;
  } chg_regs_s;

endpackage

/* File: design/chg_regs.sv */
// Charger control registers, event flags and interrupt pin drive.
//
// Contract
// - Charge enable low halts charging or boost.
// - Boost enable set by write or pin.
// - Battery temperature enable gates temperature effects.
// - Junction option reduces current when hot.
// - Force end of charge above recharge.
// - Timer reset bit restarts timer, self-clears.
// - Interrupt pin global mask suppresses requests.
// - Disable bits stop watchdog and charge timer.
// - Power path bit enables power path.
// - Transceiver supply bit powers transceiver output.
// - Flag pin global mask suppresses flag.
// - Source select picks pins or registers.
// - Input limit enable applies limit setting.
// - Auto current enable activates auto control.
// - Status bits 5..2 report die thresholds.
// - Status bit 0 input in range.
// - First charger register flags four conditions.
// - Bit 0 shows other bank pending.
// - Second register flags battery hot, cold.
// - Three timers raise separate timeout flags.
// - Boost bit 2 flags bus overload.
// - Reading a register clears its flags.
// - Register reset bit restores all registers.
// - Interrupt pin low while flags pending.
`timescale 1ns/100ps
`include "chg_params.svh"
module chg_regs
  import chg_pkg::*;
#(
  parameter chg_count_t WDOG_CYCLES = `CHG_WDOG_CYCLES,
  parameter chg_count_t BUS_CYCLES = `CHG_BUS_CYCLES,
  parameter chg_count_t CTMR_CYCLES = `CHG_CTMR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic boost_req_pin,
  input wire logic boost_mode_entry,
  input wire logic charge_mode_entry,
  input wire logic charger_active,
  input wire logic bus_input_active,
  input wire logic vbat_above_recharge,
  input wire logic die_temp_warn,
  input wire logic die_temp_first,
  input wire logic die_temp_second,
  input wire logic die_shutdown,
  input wire logic input_in_range,
  input wire logic input_low,
  input wire logic input_overvoltage,
  input wire logic battery_sense_out,
  input wire logic battery_overvoltage,
  input wire logic battery_hot,
  input wire logic battery_cold,
  input wire logic bus_overload,
  output logic charge_enable_bit,
  output logic boost_enable_bit,
  output logic boost_run,
  output logic battery_temp_enable,
  output logic battery_temp_fault,
  output logic junction_temp_option,
  output logic charge_current_reduce,
  output logic force_end_of_charge,
  output logic end_of_charge_apply,
  output logic charge_timer_restart,
  output logic watchdog_disable,
  output logic charge_timer_disable,
  output logic power_path_enable,
  output logic transceiver_supply_enable,
  output logic flag_pin_global_mask,
  output logic input_limit_source_select,
  output logic input_limit_enable,
  output logic auto_current_enable,
  output logic irq_request_pin_n,
  output logic flag_irq_request
);

  chg_regs_s s_q; // Registered state of the bank.
  chg_regs_s s_d; // Next state of the bank.

  logic [`CHG_NFLAGS-1:0] cond; // Raw conditions behind each flag.
  logic [`CHG_NFLAGS-1:0] clr; // Per-flag clear request.
  logic [`CHG_NFLAGS-1:0] flags; // Sticky flag outputs.
  logic wr_charge_control_one; // Write strobe aimed at control one.
  logic soft_rst; // Register reset requested by software.
  logic tmr_rst; // Timer reset event, one cycle long.
  logic wdog_exp; // Watchdog expired level.
  logic bus_exp; // Bus input timer expired level.
  logic ctmr_exp; // Charge timer expired level.
  logic ch1_any; // Some first-bank flag pending.
  logic ch2_any; // Some second-bank flag pending.

  // Decode a read strobe for one register offset.
  function automatic logic rd_hit(input logic [7:0] a);
    rd_hit = reg_rd && (reg_addr == a);
  endfunction

  // Read view of every register; unmapped offsets and reserved bits are 0.
  function automatic logic [7:0] read_view(input logic [7:0] a);
    case (a)
      `CHG_ADDR_CHARGE_CONTROL_ONE: read_view = {1'b0, s_q.charge_control_one[6:0]};
      `CHG_ADDR_CHARGE_CONTROL_TWO: read_view = s_q.charge_control_two;
      `CHG_ADDR_STAT: read_view = {2'b00, flags[0], flags[1], flags[2],
        flags[3], 1'b0, flags[4]};
      `CHG_ADDR_CH1: read_view = {3'b000, flags[5], flags[6], flags[7],
        flags[8], ch2_any};
      `CHG_ADDR_CH2: read_view = {flags[9], 2'b00, flags[10], flags[11],
        flags[12], flags[13], ch1_any};
      `CHG_ADDR_BST: read_view = {5'b00000, flags[14], 2'b00};
      default: read_view = 8'h00;
    endcase
  endfunction

  // Software strobes that act in the cycle of the write itself.
  assign wr_charge_control_one = reg_wr && (reg_addr == `CHG_ADDR_CHARGE_CONTROL_ONE);
  assign soft_rst = wr_charge_control_one && reg_wdata[`CHG_C1_REG_RST];
  // The stored timer reset bit is the one-cycle timer reset event.
  assign tmr_rst = s_q.charge_control_one[`CHG_C1_TMR_RST];

  // Gather the raw conditions in flag vector order.
  always_comb begin
    cond[0] = die_temp_warn;
    cond[1] = die_temp_first;
    cond[2] = die_temp_second;
    cond[3] = die_shutdown;
    cond[4] = input_in_range;
    cond[5] = input_low;
    cond[6] = input_overvoltage;
    cond[7] = battery_sense_out;
    cond[8] = battery_overvoltage;
    cond[9] = battery_hot;
    cond[10] = battery_cold;
    cond[11] = wdog_exp;
    cond[12] = bus_exp;
    cond[13] = ctmr_exp;
    cond[14] = bus_overload;
  end

  // Watchdog is kicked by any register write or a timer reset.
  chg_timer #(
    .CYCLES(WDOG_CYCLES)
  ) u_wdog (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(charger_active && !s_q.charge_control_two[`CHG_C2_WDOG_DIS]),
    .restart(reg_wr || tmr_rst),
    .expired(wdog_exp)
  );

  // Bus input timer runs while the input path is in use.
  chg_timer #(
    .CYCLES(BUS_CYCLES)
  ) u_bus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(bus_input_active),
    .restart(tmr_rst || soft_rst),
    .expired(bus_exp)
  );

  // Charge safety timer, restarted by the self-clearing reset bit.
  chg_timer #(
    .CYCLES(CTMR_CYCLES)
  ) u_ctmr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(charger_active && !s_q.charge_control_two[`CHG_C2_CTMR_DIS]),
    .restart(tmr_rst || soft_rst),
    .expired(ctmr_exp)
  );

  // One flag per condition; the edge type and clear sources are per bit.
  genvar gi;
  generate
    for (gi = 0; gi < `CHG_NFLAGS; gi = gi + 1) begin : g_flag
      localparam logic [`CHG_NFLAGS-1:0] DM = `CHG_FL_DUAL;
      localparam logic [`CHG_NFLAGS-1:0] MS = `CHG_FL_STAT;
      localparam logic [`CHG_NFLAGS-1:0] M1 = `CHG_FL_CH1;
      localparam logic [`CHG_NFLAGS-1:0] M2 = `CHG_FL_CH2;
      localparam logic [`CHG_NFLAGS-1:0] MB = `CHG_FL_BST;
      localparam logic [`CHG_NFLAGS-1:0] BO = `CHG_FL_BOOST_CLR;
      localparam logic [`CHG_NFLAGS-1:0] CH = `CHG_FL_CHG_CLR;
      localparam logic [`CHG_NFLAGS-1:0] TR = `CHG_FL_TMR_CLR;
      // Read of the owning register clears; so do reset and mode events.
      assign clr[gi] = soft_rst
        || (MS[gi] && rd_hit(`CHG_ADDR_STAT))
        || (M1[gi] && rd_hit(`CHG_ADDR_CH1))
        || (M2[gi] && rd_hit(`CHG_ADDR_CH2))
        || (MB[gi] && rd_hit(`CHG_ADDR_BST))
        || (BO[gi] && boost_mode_entry)
        || (CH[gi] && charge_mode_entry)
        || (TR[gi] && tmr_rst);
      chg_edge_flag #(
        .DUAL(DM[gi])
      ) u_flag (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cond(cond[gi]),
        .clr(clr[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  // Cross-bank pending indicators are read-only and never cleared here.
  assign ch1_any = |(flags & `CHG_FL_CH1);
  assign ch2_any = |(flags & `CHG_FL_CH2);

  // Next state of control registers, read data and pin drivers.
  always_comb begin
    s_d = s_q;
    s_d.boost_pin_prev = boost_req_pin;
    // The timer reset bit lives for one cycle only.
    s_d.charge_control_one[`CHG_C1_TMR_RST] = 1'b0;
    if (soft_rst) begin
      // Register reset drops the data of the write that asked for it.
      s_d.charge_control_one = `CHG_CHARGE_CONTROL_ONE_RST;
      s_d.charge_control_two = `CHG_CHARGE_CONTROL_TWO_RST;
    end else begin
      if (wr_charge_control_one) begin
        // Bit 7 is never stored, so it reads back as zero.
        s_d.charge_control_one = {1'b0, reg_wdata[6:0]};
      end
      if (reg_wr && reg_addr == `CHG_ADDR_CHARGE_CONTROL_TWO) begin
        s_d.charge_control_two = reg_wdata;
      end
      if (boost_mode_entry) begin
        // Boost entry restores the mode-sensitive control two bits.
        s_d.charge_control_two = (s_d.charge_control_two & ~`CHG_C2_BOOST_RST_MASK)
          | (`CHG_CHARGE_CONTROL_TWO_RST & `CHG_C2_BOOST_RST_MASK);
      end
      if (charge_mode_entry) begin
        s_d.charge_control_one[`CHG_C1_BOOST_EN] = 1'b0;
      end
      // A pin request arriving with a charge entry still wins.
      if (boost_req_pin && !s_q.boost_pin_prev) begin
        s_d.charge_control_one[`CHG_C1_BOOST_EN] = 1'b1;
      end
    end
    // Reads return the view before any clear this cycle takes effect.
    if (reg_rd) begin
      s_d.rdata = read_view(reg_addr);
    end
    // Interrupt pin is low while anything is pending and unmasked.
    s_d.irq_n = !((|flags) && !s_q.charge_control_one[`CHG_C1_IRQ_MASK]);
    s_d.flag_req = (|flags) && !s_q.charge_control_two[`CHG_C2_FLAG_MASK];
    // Charge enable low also stops boost operation.
    s_d.boost_run = s_q.charge_control_one[`CHG_C1_BOOST_EN]
      && s_q.charge_control_one[`CHG_C1_CHARGE_ENABLE_BIT];
    s_d.batt_temp_fault = s_q.charge_control_one[`CHG_C1_BATT_TEMP]
      && (battery_hot || battery_cold);
    s_d.current_reduce = s_q.charge_control_one[`CHG_C1_TJ_OPT]
      && die_temp_warn;
    s_d.eoc_force = s_q.charge_control_one[`CHG_C1_FORCE_EOC]
      && vbat_above_recharge;
  end

  // Single register stage; reset leaves the pins idle and masked.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.charge_control_one <= `CHG_CHARGE_CONTROL_ONE_RST;
      s_q.charge_control_two <= `CHG_CHARGE_CONTROL_TWO_RST;
      s_q.irq_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a bit of the registered state.
  assign reg_rdata = s_q.rdata;
  assign charge_enable_bit = s_q.charge_control_one[`CHG_C1_CHARGE_ENABLE_BIT];
  assign boost_enable_bit = s_q.charge_control_one[`CHG_C1_BOOST_EN];
  assign boost_run = s_q.boost_run;
  assign battery_temp_enable = s_q.charge_control_one[`CHG_C1_BATT_TEMP];
  assign battery_temp_fault = s_q.batt_temp_fault;
  assign junction_temp_option = s_q.charge_control_one[`CHG_C1_TJ_OPT];
  assign charge_current_reduce = s_q.current_reduce;
  assign force_end_of_charge = s_q.charge_control_one[`CHG_C1_FORCE_EOC];
  assign end_of_charge_apply = s_q.eoc_force;
  assign charge_timer_restart = s_q.charge_control_one[`CHG_C1_TMR_RST];
  assign watchdog_disable = s_q.charge_control_two[`CHG_C2_WDOG_DIS];
  assign charge_timer_disable = s_q.charge_control_two[`CHG_C2_CTMR_DIS];
  assign power_path_enable = s_q.charge_control_two[`CHG_C2_POWER_PATH_ENABLE];
  assign transceiver_supply_enable = s_q.charge_control_two[`CHG_C2_XCVR_EN];
  assign flag_pin_global_mask = s_q.charge_control_two[`CHG_C2_FLAG_MASK];
  assign input_limit_source_select = s_q.charge_control_two[`CHG_C2_ILIM_SRC];
  assign input_limit_enable = s_q.charge_control_two[`CHG_C2_ILIM_EN];
  assign auto_current_enable = s_q.charge_control_two[`CHG_C2_AUTO_CURRENT_ENABLE];
  assign irq_request_pin_n = s_q.irq_n;
  assign flag_irq_request = s_q.flag_req;

endmodule

/* File: design/chg_timer.sv */
// Timeout timer that counts while running and holds its expiry level.
`timescale 1ns/100ps
module chg_timer
  import chg_pkg::*;
#(
  parameter chg_count_t CYCLES = 40'h0000000010
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  output logic expired
);

  chg_timer_s s_q; // Registered state.
  chg_timer_s s_d; // Next state.

  // Count while running; a restart wins and rearms the timer.
  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d = '0;
    end else if (run && !s_q.expired) begin
      if (s_q.cnt == CYCLES - 40'h0000000001) begin
        s_d.expired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 40'h0000000001;
      end
    end
  end

  // Pausing keeps the count, so a stopped timer resumes where it was.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

endmodule

/* File: verification/chg_host_model.sv */
// Host processor model that drives the byte register port.
`timescale 1ns/100ps
module chg_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // The bus starts idle with both strobes low.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end

  // One write strobe; address and data hold through the taking edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge ref_clk);
    reg_wr = 1'h0;
    // Released data is scrambled so that nothing leans on it.
    reg_wdata = ~d;
  endtask

  // One read strobe; the registered answer is taken a cycle later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

/* File: verification/chg_regs_asserts.sv */
// Concurrent checks on the charger register bank ports.
`timescale 1ns/100ps
module chg_regs_asserts (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic boost_req_pin,
  input wire logic boost_mode_entry,
  input wire logic charge_mode_entry,
  input wire logic vbat_above_recharge,
  input wire logic charge_enable_bit,
  input wire logic boost_enable_bit,
  input wire logic boost_run,
  input wire logic force_end_of_charge,
  input wire logic end_of_charge_apply,
  input wire logic charge_timer_restart,
  input wire logic power_path_enable,
  input wire logic input_limit_enable,
  input wire logic flag_pin_global_mask,
  input wire logic flag_irq_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A plain write to control one; a soft reset write is left out.
  logic c1_wr;
  assign c1_wr = reg_wr && reg_addr == 8'h01 && !reg_wdata[7];

  a_charge_en_write: assert property (
    c1_wr |=> charge_enable_bit == $past(reg_wdata[6]))
    else $error("charge enable does not follow its write");
  a_timer_pulse_once: assert property (
    c1_wr && reg_wdata[1] |=> charge_timer_restart ##1 !charge_timer_restart)
    else $error("timer restart is not a single pulse");
  a_pin_sets_boost: assert property (
    $rose(boost_req_pin) |=> boost_enable_bit)
    else $error("boost pin edge did not set boost enable");
  a_charge_clears_boost: assert property (
    charge_mode_entry && !boost_req_pin && !reg_wr |=> !boost_enable_bit)
    else $error("charge mode entry left boost enabled");
  a_boost_run_gated: assert property (
    boost_run == $past(boost_enable_bit && charge_enable_bit))
    else $error("boost run not gated by charge enable");
  a_eoc_gated: assert property (
    end_of_charge_apply == $past(force_end_of_charge && vbat_above_recharge))
    else $error("end of charge apply wrong");
  a_flag_mask_quiet: assert property (
    flag_pin_global_mask |=> !flag_irq_request)
    else $error("flag request while globally masked");
  a_charge_control_two_write: assert property (
    reg_wr && reg_addr == 8'h02 && !boost_mode_entry
      |=> power_path_enable == $past(reg_wdata[5])
      && input_limit_enable == $past(reg_wdata[1]))
    else $error("control two write not applied");
  a_reserved_zero: assert property (
    reg_rd && reg_addr == 8'h06 |=> reg_rdata[7:3] == 5'h00
      && reg_rdata[1:0] == 2'h0)
    else $error("reserved boost flag bits not zero");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h06) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  c_soft_reset: cover property (reg_wr && reg_addr == 8'h01 && reg_wdata[7]);
  c_flag_pin: cover property ($rose(flag_irq_request));
  c_boost_run: cover property ($rose(boost_run));
endmodule

/* File: verification/chg_regs_tb_top.sv */
// Self-checking bench for the charger register bank.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module chg_regs_tb_top;
  logic ref_clk = 1'h0, rst_n = 1'h0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  // Condition inputs all start low at time zero.
  logic boost_req_pin = 1'h0, charge_mode_entry = 1'h0;
  logic boost_mode_entry = 1'h0;
  logic charger_active = 1'h0, bus_input_active = 1'h0;
  logic vbat_above_recharge = 1'h0, die_temp_warn = 1'h0;
  logic die_temp_first = 1'h0, die_temp_second = 1'h0, die_shutdown = 1'h0;
  logic input_in_range = 1'h0, input_low = 1'h0, input_overvoltage = 1'h0;
  logic battery_sense_out = 1'h0, battery_overvoltage = 1'h0;
  logic battery_hot = 1'h0, bus_overload = 1'h0;
  logic charge_enable_bit, boost_enable_bit, boost_run, battery_temp_fault;
  logic charge_current_reduce, end_of_charge_apply, power_path_enable;
  logic transceiver_supply_enable, input_limit_enable, irq_request_pin_n;
  logic flag_irq_request;
  int failures = 0, samples_checked = 0, cycles = 0;

  // Short timer counts keep the expiry tests brief.
  chg_regs #(.WDOG_CYCLES(40'h14), .BUS_CYCLES(40'h1E),
    .CTMR_CYCLES(40'h28)) u_dut (
    .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .boost_req_pin, .boost_mode_entry, .charge_mode_entry,
    .charger_active, .bus_input_active, .vbat_above_recharge,
    .die_temp_warn, .die_temp_first, .die_temp_second, .die_shutdown,
    .input_in_range, .input_low, .input_overvoltage, .battery_sense_out,
    .battery_overvoltage, .battery_hot, .battery_cold(1'h0), .bus_overload,
    .charge_enable_bit, .boost_enable_bit, .boost_run,
    .battery_temp_enable(), .battery_temp_fault, .junction_temp_option(),
    .charge_current_reduce, .force_end_of_charge(), .end_of_charge_apply,
    .charge_timer_restart(), .watchdog_disable(), .charge_timer_disable(),
    .power_path_enable, .transceiver_supply_enable,
    .flag_pin_global_mask(), .input_limit_source_select(),
    .input_limit_enable, .auto_current_enable(), .irq_request_pin_n,
    .flag_irq_request);
  chg_host_model u_host (.ref_clk, .reg_rdata, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd);

  always #5 ref_clk = ~ref_clk;

  // A hung sequence is cut short well past its expected length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Reads one register and compares it with the expected byte.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    `CHK("register read", e, d)
  endtask

  // Waits a number of falling edges.
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  initial begin
    idle(2);
    rst_n = 1'h1;
    rchk(8'h01, 8'h51);
    rchk(8'h02, 8'h1E);
    // All three timers expire while charging with no writes.
    charger_active = 1'h1;
    bus_input_active = 1'h1;
    idle(45);
    rchk(8'h05, 8'h0E);
    rchk(8'h05, 8'h00);
    // Timer reset rearms them; the flags then clear without a read.
    u_host.wr(8'h01, 8'h53);
    idle(45);
    charger_active = 1'h0;
    bus_input_active = 1'h0;
    rchk(8'h04, 8'h01);
    u_host.wr(8'h01, 8'h53);
    rchk(8'h04, 8'h00);
    rchk(8'h01, 8'h51);
    // A flag stays off both pins while the global masks are set.
    battery_hot = 1'h1;
    idle(3);
    `CHK("irq masked", 1'h1, irq_request_pin_n)
    `CHK("flag masked", 1'h0, flag_irq_request)
    `CHK("temp fault", 1'h1, battery_temp_fault)
    u_host.wr(8'h01, 8'h40);
    u_host.wr(8'h02, 8'h16);
    idle(2);
    `CHK("irq pin", 1'h0, irq_request_pin_n)
    `CHK("flag pin", 1'h1, flag_irq_request)
    `CHK("temp ignored", 1'h0, battery_temp_fault)
    rchk(8'h05, 8'h80);
    idle(2);
    `CHK("irq released", 1'h1, irq_request_pin_n)
    battery_hot = 1'h0;
    idle(2);
    rchk(8'h05, 8'h80);
    // Every status and first charger condition at once.
    die_temp_warn = 1'h1;
    die_temp_first = 1'h1;
    die_temp_second = 1'h1;
    die_shutdown = 1'h1;
    input_in_range = 1'h1;
    input_low = 1'h1;
    input_overvoltage = 1'h1;
    battery_sense_out = 1'h1;
    battery_overvoltage = 1'h1;
    idle(2);
    rchk(8'h03, 8'h3D);
    rchk(8'h03, 8'h00);
    rchk(8'h05, 8'h01);
    rchk(8'h04, 8'h1E);
    // Charge halted with junction option and forced end of charge.
    u_host.wr(8'h01, 8'h0C);
    vbat_above_recharge = 1'h1;
    idle(2);
    `CHK("charge enable", 1'h0, charge_enable_bit)
    `CHK("current reduce", 1'h1, charge_current_reduce)
    `CHK("eoc apply", 1'h1, end_of_charge_apply)
    u_host.wr(8'h02, 8'hE1);
    rchk(8'h02, 8'hE1);
    `CHK("power path", 1'h1, power_path_enable)
    `CHK("transceiver", 1'h0, transceiver_supply_enable)
    `CHK("input limit", 1'h0, input_limit_enable)
    // Boost requested by pin, then dropped by charge mode entry.
    u_host.wr(8'h01, 8'h40);
    boost_req_pin = 1'h1;
    idle(2);
    `CHK("boost enable", 1'h1, boost_enable_bit)
    `CHK("boost run", 1'h1, boost_run)
    boost_req_pin = 1'h0;
    charge_mode_entry = 1'h1;
    idle(1);
    charge_mode_entry = 1'h0;
    idle(1);
    `CHK("boost cleared", 1'h0, boost_enable_bit)
    // Overload flag cleared by charge entry, then set by the falling edge.
    bus_overload = 1'h1;
    idle(2);
    charge_mode_entry = 1'h1;
    idle(1);
    charge_mode_entry = 1'h0;
    rchk(8'h06, 8'h00);
    bus_overload = 1'h0;
    idle(2);
    rchk(8'h06, 8'h04);
    // Boost entry restores the mode bits of control two, clears range flag.
    input_in_range = 1'h0;
    idle(2);
    boost_mode_entry = 1'h1;
    idle(1);
    boost_mode_entry = 1'h0;
    rchk(8'h02, 8'h06);
    rchk(8'h03, 8'h00);
    // Refused accesses, then a soft reset.
    u_host.wr(8'h03, 8'hFF);
    rchk(8'h03, 8'h00);
    rchk(8'h07, 8'h00);
    u_host.wr(8'h01, 8'h80);
    rchk(8'h01, 8'h51);
    rchk(8'h02, 8'h1E);
    report_and_stop();
  end
endmodule

bind chg_regs chg_regs_asserts u_chk (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .boost_req_pin, .boost_mode_entry, .charge_mode_entry, .vbat_above_recharge,
  .charge_enable_bit, .boost_enable_bit, .boost_run, .force_end_of_charge,
  .end_of_charge_apply, .charge_timer_restart, .power_path_enable,
  .input_limit_enable, .flag_pin_global_mask, .flag_irq_request);
